// *** sesm_cfg.svh ***
/*
 * constants of the enhanced serial message generator: schedule ids,
 * schedule positions, frame counts, crc constants, register offsets
 * and reset values.
 * assumes it is included by bare name from each design file.
 */
`ifndef SESM_CFG_SVH
`define SESM_CFG_SVH

// message shape
`define SESM_LAST_FRAME 5'h11
`define SESM_LAST_POS 5'h1d
`define SESM_START_ONES 6'h3f
`define SESM_CFG_BIT 1'b0
`define SESM_START_END_FRAME 5'h06
`define SESM_CFG_FRAME 5'h07
`define SESM_DATA_FIRST_FRAME 5'h06
`define SESM_SPACER_FRAME 5'h0c

// message identifiers
`define SESM_ID_FAIL 8'h01
`define SESM_ID_TEMP 8'h23
`define SESM_ID_STYPE 8'h03
`define SESM_ID_MANUF 8'h05
`define SESM_ID_PROTO 8'h06
`define SESM_ID_EXC 8'h83
`define SESM_ID_VREC 8'h85
`define SESM_ID_DEVID 8'h87

// schedule positions, counted from zero
`define SESM_P_TEMP_A 5'h01
`define SESM_P_STYPE 5'h05
`define SESM_P_MANUF 5'h09
`define SESM_P_PROTO 5'h0d
`define SESM_P_TEMP_B 5'h11
`define SESM_P_EXC 5'h15
`define SESM_P_VREC 5'h19
`define SESM_P_DEVID 5'h1d

// amplitude slice carried in its message
`define SESM_VREC_HI 16
`define SESM_VREC_LO 5

// six-bit crc, seed and polynomial low bits
`define SESM_CRC_SEED 6'h15
`define SESM_CRC_POLY 6'h19

// register byte offsets
`define SESM_A_STYPE 8'h00
`define SESM_A_MANUF 8'h04
`define SESM_A_PROTO 8'h08
`define SESM_A_DEVID 8'h0c
`define SESM_A_PAGES 8'h10
`define SESM_A_STATUS 8'h14
`define SESM_A_USER_LO 8'h40
`define SESM_A_USER_HI 8'h74

// register reset values
`define SESM_RST_STYPE 12'h000
`define SESM_RST_MANUF 12'h000
`define SESM_RST_PROTO 12'h000
`define SESM_RST_DEVID 12'h000
`define SESM_RST_PAGES 16'h4321
`define SESM_RST_USER 16'h0000

`endif

// *** sesm_pkg.sv ***
/*
 * types shared by the enhanced serial message generator.
 * assumes nothing of its surroundings.
 */
package sesm_pkg;
  // register bus handshake states, one-hot
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK = 2'b10
  } sesm_bus_e;
endpackage : sesm_pkg

// *** sesm_user_mem.sv ***
/*
 * small memory of the user-data slots: ident nibble and data word
 * per slot, one write port, one read port with registered data.
 * assumes a single clock and a synchronous active-low reset.
 */
`timescale 1ns/1ns
`include "sesm_cfg.svh"

module sesm_user_mem #(
  parameter int DEPTH = 14,
  parameter int AW = 4,
  parameter int WIDTH = 16
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic nrst_in,
  // write port
  input wire logic we_in,
  input wire logic [AW-1:0] waddr_in,
  input wire logic [WIDTH-1:0] wdata_in,
  // read port
  input wire logic [AW-1:0] raddr_in,
  output logic [WIDTH-1:0] rdata_out
);

  logic [WIDTH-1:0] mem_q [DEPTH]; // slot words

  // write and registered read; reset clears every slot
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= `SESM_RST_USER;
      end
      rdata_out <= `SESM_RST_USER;
    end else begin
      if (we_in && (int'(waddr_in) < DEPTH)) begin
        mem_q[waddr_in] <= wdata_in;
      end
      rdata_out <= (int'(raddr_in) < DEPTH) ? mem_q[raddr_in] : '0;
    end
  end

endmodule : sesm_user_mem

// *** sesm_tx.sv ***
/*
 * enhanced serial message generator for the status nibble of each
 * frame, with fault gating of the output driver and a wishbone slave.
 * assumes a frame builder on the same clock that pulses frame_start_in
 * once per frame (at least two cycles apart) and then sends
 * status_nibble_out; the fault pin comes from outside the clock domain.
 */
// Summary of operation
// RL1: serial channel only in status bits 2, 3
// RL2: one message spans exactly 18 frames
// RL3: bit 3 starts with six ones, one zero
// RL4: then config bit zero and 8-bit id
// RL5: bit 2 carries only crc and data
// RL6: sequencer free running, faults never restart it
// RL7: output driver off while pin fault persists
// RL8: receiver resyncs on next start pattern
// RL9: every fourth message: id 01, fail flags
// RL10: positions 2, 18: id 23, temperature
// RL11: position 6: id 03, sensor type
// RL12: position 10: id 05, manufacturer code
// RL13: position 14: id 06, protocol revision
// RL14: position 22: id 83, excitation current
// RL15: position 26: id 85, amplitude bits 16:5
// RL16: position 30: id 87, device ident value
// RL17: user id is page times 16 plus nibble
// RL18: user slot pairs, pages 1 to 4
// RL19: after position 30 wrap to position 1
// RL20: standard enhanced format, crc and placement
// RL21: low status bits carry channel errors
`timescale 1ns/1ns
`include "sesm_cfg.svh"

module sesm_tx (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic nrst_in,
  // frame builder side
  input wire logic frame_start_in,
  input wire logic [1:0] ch_err_in,
  output logic [3:0] status_nibble_out,
  // on-chip data sources
  input wire logic [8:0] fail_flags_in,
  input wire logic [11:0] temp_code_in,
  input wire logic [7:0] preset_current_in,
  input wire logic [16:0] receiver_coil_voltage_in,
  // output pin fault and driver
  input wire logic pin_fault_in,
  output logic sent_drv_en_out,
  // wishbone slave
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic [3:0] wb_sel_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out
);

  // six-bit crc over the 24 message bits, augmented by six zeros
  function automatic logic [5:0] crc6(input logic [23:0] bits);
    logic [5:0] c;
    logic [29:0] stream;
    logic fb;
    c = `SESM_CRC_SEED;
    stream = {bits, 6'h00};
    fb = 1'b0;
    for (int i = 29; i >= 0; i--) begin
      fb = c[5] ^ stream[i];
      c = {c[4:0], 1'b0};
      if (fb) begin
        c = c ^ `SESM_CRC_POLY;
      end
    end
    return c;
  endfunction : crc6

  // byte-lane merge of a write into a register value
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wr,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = wr[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // sequencer state
  logic [4:0] frm_q, frm_d; // frame within message
  logic [4:0] pos_q, pos_d; // schedule position, from zero
  logic [17:0] sh3_q, sh3_d; // bit 3 bits still to send
  logic [17:0] sh2_q, sh2_d; // bit 2 bits still to send
  logic [3:0] nib_q, nib_d; // status nibble to the frame builder
  logic [7:0] id_q, id_d; // id of message in flight
  logic [11:0] dat_q, dat_d; // data of message in flight
  // fault path
  logic fs1_q, fs2_q; // pin fault synchroniser
  logic drv_q, drv_d; // driver enable
  // configuration registers
  logic [11:0] stype_q, stype_d; // sensor type value
  logic [11:0] manuf_q, manuf_d; // manufacturer code
  logic [11:0] proto_q, proto_d; // protocol revision
  logic [11:0] devid_q, devid_d; // device_ident_value
  logic [15:0] pages_q, pages_d; // user_page_nibble_4..1
  // bus slave
  sesm_pkg::sesm_bus_e bst_q, bst_d; // handshake state
  logic ack_q, ack_d; // acknowledge
  logic [31:0] rdat_q, rdat_d; // read data
  // user memory ports
  logic mem_we; // write strobe
  logic [3:0] mem_waddr; // slot written
  logic [15:0] mem_rdata; // {user_slot_ident_nibble, data}
  // message assembly
  logic [7:0] cur_id; // id for current position
  logic [11:0] cur_dat; // data for current position
  logic [17:0] vec3, vec2; // fresh message vectors
  logic [17:0] cur3, cur2; // bits in use this frame
  logic [3:0] page_nib; // page nibble of the slot pair

  // user slots live in their own memory, read by position
  sesm_user_mem #(
    .DEPTH(14),
    .AW(4),
    .WIDTH(16)
  ) u_user_mem (
    .core_clk_in(core_clk_in),
    .nrst_in(nrst_in),
    .we_in(mem_we),
    .waddr_in(mem_waddr),
    .wdata_in(wb_dat_in[15:0]),
    .raddr_in({pos_q[4:2], pos_q[0]}), // [RL18]
    .rdata_out(mem_rdata)
  );

  // picks id and data of the message at the current position
  always_comb begin
    page_nib = pages_q[{pos_q[4:3], 2'b00} +: 4]; // [RL18]
    cur_id = `SESM_ID_FAIL; // [RL9]
    cur_dat = {3'h0, fail_flags_in}; // [RL9]
    if (pos_q[1]) begin
      // user slot pair: page times 16 plus slot nibble
      cur_id = {page_nib, mem_rdata[15:12]}; // [RL17]
      cur_dat = mem_rdata[11:0]; // [RL17]
    end else if (pos_q[0]) begin
      unique case (pos_q)
        `SESM_P_TEMP_A, `SESM_P_TEMP_B: begin
          cur_id = `SESM_ID_TEMP; // [RL10]
          cur_dat = temp_code_in;
        end
        `SESM_P_STYPE: begin
          cur_id = `SESM_ID_STYPE; // [RL11]
          cur_dat = stype_q;
        end
        `SESM_P_MANUF: begin
          cur_id = `SESM_ID_MANUF; // [RL12]
          cur_dat = manuf_q;
        end
        `SESM_P_PROTO: begin
          cur_id = `SESM_ID_PROTO; // [RL13]
          cur_dat = proto_q;
        end
        `SESM_P_EXC: begin
          cur_id = `SESM_ID_EXC; // [RL14]
          cur_dat = {4'h0, preset_current_in};
        end
        `SESM_P_VREC: begin
          cur_id = `SESM_ID_VREC; // [RL15]
          cur_dat = receiver_coil_voltage_in[`SESM_VREC_HI:`SESM_VREC_LO];
        end
        `SESM_P_DEVID: begin
          cur_id = `SESM_ID_DEVID; // [RL16]
          cur_dat = devid_q;
        end
        default: begin
          // no other position ends in 01; keep flags
          cur_id = `SESM_ID_FAIL;
          cur_dat = {3'h0, fail_flags_in};
        end
      endcase
    end
  end

  // builds the 18-frame bit vectors, first frame in the top bit
  always_comb begin
    vec3 = {`SESM_START_ONES, 1'b0, `SESM_CFG_BIT, cur_id[7:4], 1'b0,
            cur_id[3:0], 1'b0}; // [RL3] [RL4] [RL20]
    vec2 = '0;
    // crc covers frames 7..18, bit 3 then bit 2 of each
    for (int k = 0; k < 12; k++) begin
      vec2[17 - k] = 1'b0;
    end
    vec2 = {crc6(interleave(vec3[11:0], cur_dat)), cur_dat}; // [RL5]
  end

  // pairs bit 3 and bit 2 of frames 7..18 into the crc stream
  function automatic logic [23:0] interleave(input logic [11:0] b3,
                                             input logic [11:0] b2);
    logic [23:0] r;
    r = '0;
    for (int k = 0; k < 12; k++) begin
      r[2*k + 1] = b3[k];
      r[2*k] = b2[k];
    end
    return r;
  endfunction : interleave

  // next sequencer state; no fault input reaches here
  always_comb begin
    cur3 = (frm_q == 5'h00) ? vec3 : sh3_q; // [RL2]
    cur2 = (frm_q == 5'h00) ? vec2 : sh2_q;
    frm_d = frm_q;
    pos_d = pos_q;
    sh3_d = sh3_q;
    sh2_d = sh2_q;
    nib_d = nib_q;
    id_d = id_q;
    dat_d = dat_q;
    if (frame_start_in) begin
      // serial bits only in 3 and 2, errors below
      nib_d = {cur3[17], cur2[17], ch_err_in}; // [RL1] [RL21]
      sh3_d = {cur3[16:0], 1'b0};
      sh2_d = {cur2[16:0], 1'b0};
      if (frm_q == 5'h00) begin
        id_d = cur_id;
        dat_d = cur_dat;
      end
      if (frm_q == `SESM_LAST_FRAME) begin
        frm_d = 5'h00; // [RL2]
        // wrap after the last schedule entry
        pos_d = (pos_q == `SESM_LAST_POS) ? 5'h00 : pos_q + 5'h01; // [RL19]
      end else begin
        frm_d = frm_q + 5'h01; // [RL6]
      end
    end
  end

  // registers the sequencer
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      frm_q <= 5'h00;
      pos_q <= 5'h00;
      sh3_q <= '0;
      sh2_q <= '0;
      nib_q <= 4'h0;
      id_q <= 8'h00;
      dat_q <= 12'h000;
    end else begin
      frm_q <= frm_d;
      pos_q <= pos_d;
      sh3_q <= sh3_d;
      sh2_q <= sh2_d;
      nib_q <= nib_d;
      id_q <= id_d;
      dat_q <= dat_d;
    end
  end

  // driver enable follows the synchronised pin fault
  always_comb begin
    drv_d = ~fs2_q; // [RL7]
  end

  // registers the fault path; first stage feeds only the second
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      fs1_q <= 1'b0;
      fs2_q <= 1'b0;
      drv_q <= 1'b0;
    end else begin
      fs1_q <= pin_fault_in;
      fs2_q <= fs1_q;
      drv_q <= drv_d;
    end
  end

  // bus decode: one wait state, writes and reads at the take edge
  always_comb begin
    bst_d = bst_q;
    ack_d = 1'b0;
    rdat_d = rdat_q;
    stype_d = stype_q;
    manuf_d = manuf_q;
    proto_d = proto_q;
    devid_d = devid_q;
    pages_d = pages_q;
    mem_we = 1'b0;
    mem_waddr = 4'(wb_adr_in[7:2] - 6'h10);
    unique case (bst_q)
      sesm_pkg::BUS_IDLE: begin
        if (wb_cyc_in && wb_stb_in) begin
          bst_d = sesm_pkg::BUS_ACK;
          ack_d = 1'b1;
          rdat_d = 32'h0000_0000; // unmapped reads zero
          unique case (wb_adr_in)
            `SESM_A_STYPE: begin
              rdat_d = {20'h00000, stype_q};
              if (wb_we_in) begin
                stype_d = 12'(merge({20'h0, stype_q}, wb_dat_in, wb_sel_in));
              end
            end
            `SESM_A_MANUF: begin
              rdat_d = {20'h00000, manuf_q};
              if (wb_we_in) begin
                manuf_d = 12'(merge({20'h0, manuf_q}, wb_dat_in, wb_sel_in));
              end
            end
            `SESM_A_PROTO: begin
              rdat_d = {20'h00000, proto_q};
              if (wb_we_in) begin
                proto_d = 12'(merge({20'h0, proto_q}, wb_dat_in, wb_sel_in));
              end
            end
            `SESM_A_DEVID: begin
              rdat_d = {20'h00000, devid_q};
              if (wb_we_in) begin
                devid_d = 12'(merge({20'h0, devid_q}, wb_dat_in, wb_sel_in));
              end
            end
            `SESM_A_PAGES: begin
              rdat_d = {16'h0000, pages_q};
              if (wb_we_in) begin
                pages_d = 16'(merge({16'h0, pages_q}, wb_dat_in, wb_sel_in));
              end
            end
            `SESM_A_STATUS: begin
              // live state, read only
              rdat_d = {20'h00000, fs2_q, drv_q, frm_q, pos_q};
            end
            default: begin
              // user slot words, write only, both low lanes needed
              if (wb_adr_in >= `SESM_A_USER_LO &&
                  wb_adr_in <= `SESM_A_USER_HI &&
                  wb_adr_in[1:0] == 2'b00 && wb_we_in &&
                  wb_sel_in[1:0] == 2'b11) begin
                mem_we = 1'b1;
              end
            end
          endcase
        end
      end
      sesm_pkg::BUS_ACK: begin
        bst_d = sesm_pkg::BUS_IDLE; // ack drops after one cycle
      end
    endcase
  end

  // registers the bus slave and configuration
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      bst_q <= sesm_pkg::BUS_IDLE;
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
      stype_q <= `SESM_RST_STYPE;
      manuf_q <= `SESM_RST_MANUF;
      proto_q <= `SESM_RST_PROTO;
      devid_q <= `SESM_RST_DEVID;
      pages_q <= `SESM_RST_PAGES;
    end else begin
      bst_q <= bst_d;
      ack_q <= ack_d;
      rdat_q <= rdat_d;
      stype_q <= stype_d;
      manuf_q <= manuf_d;
      proto_q <= proto_d;
      devid_q <= devid_d;
      pages_q <= pages_d;
    end
  end

  // outputs straight from flip-flops
  assign status_nibble_out = nib_q;
  assign sent_drv_en_out = drv_q;
  assign wb_dat_out = rdat_q;
  assign wb_ack_out = ack_q;

  // checks on the sequencer and driver
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);

  start_ones_a: assert property ( // [RL3]
    frame_start_in && frm_q < `SESM_START_END_FRAME
    |=> status_nibble_out[3])
    else $error("start pattern bit not one");
  start_zero_a: assert property ( // [RL3]
    frame_start_in && frm_q == `SESM_START_END_FRAME
    |=> !status_nibble_out[3])
    else $error("start pattern closing zero missing");
  config_bit_a: assert property ( // [RL4]
    frame_start_in && frm_q == `SESM_CFG_FRAME
    |=> !status_nibble_out[3])
    else $error("configuration bit not zero");
  id_spacer_a: assert property ( // [RL20]
    frame_start_in && (frm_q == `SESM_SPACER_FRAME ||
                       frm_q == `SESM_LAST_FRAME)
    |=> !status_nibble_out[3])
    else $error("spacer bit not zero");
  data_bit_a: assert property ( // [RL5]
    frame_start_in && frm_q == `SESM_DATA_FIRST_FRAME
    |=> status_nibble_out[2] == dat_q[11])
    else $error("first data bit wrong on bit 2");
  frame_wrap_a: assert property ( // [RL2]
    frame_start_in && frm_q == `SESM_LAST_FRAME
    |=> frm_q == 5'h00 && $changed(pos_q))
    else $error("message did not end after 18 frames");
  sched_wrap_a: assert property ( // [RL19]
    frame_start_in && frm_q == `SESM_LAST_FRAME && pos_q == `SESM_LAST_POS
    |=> pos_q == 5'h00)
    else $error("schedule did not wrap to first position");
  free_run_a: assert property ( // [RL6]
    frame_start_in && frm_q != `SESM_LAST_FRAME
    |=> $stable(pos_q) && frm_q == $past(frm_q) + 5'h01)
    else $error("sequencer moved out of step");
  drv_off_a: assert property ( // [RL7]
    pin_fault_in [*3] |=> !sent_drv_en_out)
    else $error("driver still on during pin fault");
  fail_id_a: assert property ( // [RL9]
    pos_q[1:0] == 2'b00 |-> cur_id == `SESM_ID_FAIL &&
    cur_dat[11:9] == 3'h0)
    else $error("failure flag message id wrong");
  err_bits_a: assert property ( // [RL21]
    frame_start_in |=> status_nibble_out[1:0] == $past(ch_err_in))
    else $error("channel error bits not carried");

  sched_wrap_c: cover property (
    frame_start_in && frm_q == `SESM_LAST_FRAME && pos_q == `SESM_LAST_POS);
  user_msg_c: cover property (frame_start_in && frm_q == 5'h00 && pos_q[1]);
  fault_run_c: cover property (!sent_drv_en_out && frame_start_in);
  temp_msg_c: cover property (
    frame_start_in && frm_q == 5'h00 && pos_q == `SESM_P_TEMP_B);

endmodule : sesm_tx

// *** sesm_ecu_model.sv ***
/*
 * receiving control unit: gathers status bits 3 and 2 of each frame,
 * finds the start pattern and decodes id, data and crc of a message.
 * assumes frames are sampled one cycle after frame_start_in.
 */
`timescale 1ns/1ns
`include "sesm_cfg.svh"

module sesm_ecu_model (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic nrst_in,
  // frame line as seen at the receiver
  input wire logic frame_start_in,
  input wire logic [3:0] status_nibble_in,
  input wire logic drv_en_in,
  // decoded message
  output logic [7:0] msg_cnt_out,
  output logic [7:0] msg_id_out,
  output logic [11:0] msg_data_out,
  output logic crc_ok_out
);
  logic taken_q; // a frame was launched one edge ago
  logic [17:0] b3_q; // bit 3 history, newest in bit 0
  logic [17:0] b2_q; // bit 2 history, newest in bit 0

  // one step of the six-bit crc generator
  function automatic logic [5:0] crc_step(input logic [5:0] c,
                                          input logic b);
    crc_step = {c[4:0], 1'b0} ^ ((c[5] ^ b) ? `SESM_CRC_POLY : 6'h00);
  endfunction : crc_step

  // gather bits, decode on a full message, lost frames flush history
  always @(posedge core_clk_in) begin : rx
    logic [17:0] n3;
    logic [17:0] n2;
    logic [5:0] c;
    if (!nrst_in) begin
      taken_q <= 1'b0;
      b3_q <= '0;
      b2_q <= '0;
      msg_cnt_out <= 8'h00;
      msg_id_out <= 8'h00;
      msg_data_out <= 12'h000;
      crc_ok_out <= 1'b0;
    end else begin
      taken_q <= frame_start_in;
      if (taken_q && !drv_en_in) begin
        // driver off: the frame never arrives, wait for a start
        b3_q <= '0;
        b2_q <= '0;
      end else if (taken_q) begin
        n3 = {b3_q[16:0], status_nibble_in[3]};
        n2 = {b2_q[16:0], status_nibble_in[2]};
        b3_q <= n3;
        b2_q <= n2;
        // six ones, zero, config zero and spacer zeros
        if (n3[17:12] == 6'h3f && n3[11:10] == 2'b00 && !n3[5] && !n3[0])
        begin
          c = `SESM_CRC_SEED;
          for (int i = 11; i >= 0; i--) begin
            c = crc_step(c, n3[i]);
            c = crc_step(c, n2[i]);
          end
          for (int i = 0; i < 6; i++) begin
            c = crc_step(c, 1'b0);
          end
          msg_cnt_out <= msg_cnt_out + 8'h01;
          msg_id_out <= {n3[9:6], n3[4:1]};
          msg_data_out <= n2[11:0];
          crc_ok_out <= (c == n2[17:12]);
        end
      end
    end
  end
endmodule : sesm_ecu_model

// *** test_sesm_tx.sv ***
/*
 * testbench of the serial message generator: sets registers over
 * wishbone, sends frames, compares decoded messages with the schedule.
 * assumes the receiver model decodes what the generator sends.
 */
`timescale 1ns/1ns
`include "sesm_cfg.svh"

module test_sesm_tx;
  logic core_clk_in, nrst_in, frame_start_in, pin_fault_in;
  logic [1:0] ch_err_in;
  logic [3:0] status_nibble_out, wb_sel_in;
  logic [8:0] fail_flags_in;
  logic [11:0] temp_code_in;
  logic [7:0] preset_current_in, wb_adr_in;
  logic [16:0] receiver_coil_voltage_in;
  logic sent_drv_en_out, wb_cyc_in, wb_stb_in, wb_we_in, wb_ack_out;
  logic [31:0] wb_dat_in, wb_dat_out, q;
  logic [7:0] msg_cnt, msg_id;
  logic [11:0] msg_data;
  logic crc_ok;
  int fail_count = 0; // mismatches
  int check_count = 0; // comparisons
  int cnt = 0; // messages the receiver should have
  localparam logic [15:0] PG = 16'hb6d2; // page nibbles written

  sesm_tx sesm_tx_i (.core_clk_in(core_clk_in), .nrst_in(nrst_in),
    .frame_start_in(frame_start_in), .ch_err_in(ch_err_in),
    .status_nibble_out(status_nibble_out), .fail_flags_in(fail_flags_in),
    .temp_code_in(temp_code_in), .preset_current_in(preset_current_in),
    .receiver_coil_voltage_in(receiver_coil_voltage_in),
    .pin_fault_in(pin_fault_in), .sent_drv_en_out(sent_drv_en_out),
    .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in),
    .wb_adr_in(wb_adr_in), .wb_dat_in(wb_dat_in), .wb_sel_in(wb_sel_in),
    .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out));

  sesm_ecu_model sesm_ecu_model_i (.core_clk_in(core_clk_in),
    .nrst_in(nrst_in), .frame_start_in(frame_start_in),
    .status_nibble_in(status_nibble_out), .drv_en_in(sent_drv_en_out),
    .msg_cnt_out(msg_cnt), .msg_id_out(msg_id), .msg_data_out(msg_data),
    .crc_ok_out(crc_ok));

  // 100 MHz clock
  initial begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end

  // compare and count
  task check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // verdict and end of run
  task complete_run;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : complete_run

  // one classic wishbone cycle, held until ack is sampled
  task wb_xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_in);
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in <= we;
    wb_adr_in <= a;
    wb_dat_in <= d;
    wb_sel_in <= 4'hf;
    // no cycle count assumed: only the watchdog ends a stuck wait
    do begin
      @(posedge core_clk_in);
    end while (wb_ack_out !== 1'b1);
    q = wb_dat_out;
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
  endtask : wb_xfer

  // one frame pulse, then check the low status bits
  task send_frame(input logic [1:0] e);
    @(posedge core_clk_in);
    frame_start_in <= 1'b1;
    ch_err_in <= e;
    @(posedge core_clk_in);
    frame_start_in <= 1'b0;
    #1 check(status_nibble_out[1:0], e);
    repeat (2) @(posedge core_clk_in);
  endtask : send_frame

  // bounded wait for the driver enable to reach a level
  task wait_drv(input logic lvl);
    for (int n = 0; n < 10 && sent_drv_en_out !== lvl; n++) begin
      @(posedge core_clk_in);
      #1;
    end
    check(sent_drv_en_out, lvl);
  endtask : wait_drv

  // expected id and data of a zero-based schedule position
  function automatic logic [19:0] exp_msg(input int p);
    int k;
    k = (p / 4) * 2 + p % 4 - 2;
    if (p % 4 == 0) exp_msg = {8'h01, 3'h0, fail_flags_in};
    else if (p == 1 || p == 17) exp_msg = {8'h23, temp_code_in};
    else if (p == 5) exp_msg = {8'h03, 12'habc};
    else if (p == 9) exp_msg = {8'h05, 12'h5e1};
    else if (p == 13) exp_msg = {8'h06, 12'h3f7};
    else if (p == 21) exp_msg = {8'h83, 4'h0, preset_current_in};
    else if (p == 25) exp_msg = {8'h85, receiver_coil_voltage_in[16:5]};
    else if (p == 29) exp_msg = {8'h87, 12'h9d4};
    else exp_msg = {PG[(p / 8) * 4 +: 4], k[3:0], 12'h5a0 + k[11:0]};
  endfunction : exp_msg

  // watchdog
  initial begin
    repeat (20000) @(posedge core_clk_in);
    fail_count++;
    complete_run;
  end

  // main sequence
  initial begin
    {nrst_in, frame_start_in, pin_fault_in, ch_err_in} = '0;
    {wb_cyc_in, wb_stb_in, wb_we_in, wb_adr_in, wb_dat_in} = '0;
    wb_sel_in = 4'hf;
    fail_flags_in = 9'h000;
    temp_code_in = 12'h7c3;
    preset_current_in = 8'h9e;
    receiver_coil_voltage_in = 17'h1b2c5;
    repeat (6) @(posedge core_clk_in);
    nrst_in <= 1'b1;
    wb_xfer(1'b0, `SESM_A_PAGES, 32'h0);
    check(q, 32'h4321);
    wb_xfer(1'b0, `SESM_A_STYPE, 32'h0);
    check(q, 32'h0);
    wb_xfer(1'b1, `SESM_A_STYPE, 32'habc);
    wb_xfer(1'b1, `SESM_A_MANUF, 32'h5e1);
    wb_xfer(1'b1, `SESM_A_PROTO, 32'h3f7);
    wb_xfer(1'b1, `SESM_A_DEVID, 32'h9d4);
    wb_xfer(1'b1, `SESM_A_PAGES, {16'h0, PG});
    for (int k = 0; k < 14; k++) begin
      wb_xfer(1'b1, 8'h40 + 8'(4 * k), {16'h0, 4'(k), 12'h5a0 + 12'(k)});
    end
    wb_xfer(1'b1, 8'h30, 32'h1234);
    wb_xfer(1'b0, 8'h30, 32'h0);
    check(q, 32'h0);
    wb_xfer(1'b0, `SESM_A_DEVID, 32'h0);
    check(q, 32'h9d4);
    wb_xfer(1'b0, 8'h40, 32'h0);
    check(q, 32'h0);
    wait_drv(1'b1);
    // 31 messages: one full schedule and the wrap to position 0
    for (int m = 0; m < 31; m++) begin
      fail_flags_in <= 9'h0a5 + 9'(m);
      for (int f = 0; f < 18; f++) begin
        if (m == 12 && f == 4) begin
          pin_fault_in <= 1'b1;
          wait_drv(1'b0);
        end
        if (m == 12 && f == 10) begin
          pin_fault_in <= 1'b0;
          wait_drv(1'b1);
        end
        send_frame(2'(f) ^ 2'(m));
      end
      if (m != 12) cnt++;
      check(msg_cnt, cnt);
      if (m != 12) begin
        check({msg_id, msg_data}, exp_msg(m % 30));
        check({msg_id, msg_data}, exp_msg(m % 30));
        check(crc_ok, 1'b1);
      end
    end
    complete_run;
  end
endmodule : test_sesm_tx
